// ### rtl/ars_pkg.sv
// Constants, types and conversion function for the ADC result SPI slave.
package ars_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned T_BUSY_NS       = 353334;
  localparam int unsigned BUSY_CYCLES_DEF =
    (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STARTUP_SAMPLES = 16;
  localparam int unsigned FRAME_BITS      = 32;

  // ****************************************************************
  // Data format codes
  // ****************************************************************
  localparam logic [31:0] POS_SAT_IN   = 32'h7fffff00;
  localparam logic [31:0] POS_SAT_OUT  = 32'h30000000;
  localparam logic [31:0] NEG_SAT_IN   = 32'h80000000;
  localparam logic [31:0] NEG_SAT_OUT  = 32'h0fffffff;
  localparam logic [31:0] NEG_OFFSET   = 32'h0fffffff;
  localparam logic [31:0] DUMMY_WORD   = 32'h80000000;
  localparam int unsigned IN_SIGN_BIT  = 31;
  localparam int unsigned OUT_SIGN_BIT = 29;
  localparam int unsigned EOC_BIT      = 31;
  localparam int unsigned SHIFT_POS    = 3;
  localparam int unsigned SHIFT_NEG_A  = 3;
  localparam int unsigned SHIFT_NEG_B  = 2;
  localparam int unsigned CMD_SEL_HI   = 25;
  localparam int unsigned CMD_SEL_LO   = 24;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  ADDR_RESULT  = 8'h00;
  localparam logic [7:0]  ADDR_CTRL    = 8'h04;
  localparam logic [7:0]  ADDR_STATUS  = 8'h08;
  localparam logic [7:0]  ADDR_CMD     = 8'h0c;
  localparam logic [31:0] CTRL_RESET   = 32'h00000000;
  localparam int unsigned CTRL_NEG2    = 0;

  // Status word layout; busy sits in bit 0.
  typedef struct packed {
    logic [25:0] zero;
    logic [1:0]  channel;
    logic        fresh;
    logic        ready;
    logic        port_en;
    logic        busy;
  } ars_status_t;

  // Serial link pins after synchronisation.
  typedef struct packed {
    logic sclk;
    logic ss_n;
    logic mosi;
  } ars_link_t;

  function automatic logic [31:0] ars_convert(input logic [31:0] din,
                                              input logic        neg2);
    logic [31:0] mag;
    mag = {1'b0, din[IN_SIGN_BIT-1:0]};
    if (din == POS_SAT_IN)
      ars_convert = POS_SAT_OUT;
    else if (din == NEG_SAT_IN)
      ars_convert = NEG_SAT_OUT;
    else if (!din[IN_SIGN_BIT])
      ars_convert = (mag >> SHIFT_POS) | (32'h1 << OUT_SIGN_BIT);
    else if (neg2)
      ars_convert = (mag >> SHIFT_NEG_B) + NEG_OFFSET;
    else
      ars_convert = (mag >> SHIFT_NEG_A) + NEG_OFFSET;
  endfunction

endpackage

// ### rtl/ars_spi_slave.sv
// ADC result SPI slave with busy line and AHB-Lite register port.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ars_spi_slave
  import ars_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES = BUSY_CYCLES_DEF,
  parameter int unsigned N_SAMPLES   = STARTUP_SAMPLES
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  // Filtered conversion results, one strobe for all channels
  input  wire logic        sample_valid_i,
  input  wire logic [31:0] sample_ch0_i,
  input  wire logic [31:0] sample_ch1_i,
  input  wire logic [31:0] sample_ch2_i,
  input  wire logic [31:0] sample_ch3_i,
  // Serial link pins
  input  wire logic        serial_clock_pin_i,
  input  wire logic        ss_n_i,
  input  wire logic        mosi_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  output logic             busy_o,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o
);

  // ****************************************************************
  // Link synchronisers and edge detection
  // ****************************************************************
  ars_link_t link_meta_q;
  ars_link_t link_sync_q;
  logic      sclk_prev_q;
  logic      sclk_rise;
  logic      sclk_fall;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      link_meta_q <= '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0};
      link_sync_q <= '{sclk: 1'b0, ss_n: 1'b1, mosi: 1'b0};
      sclk_prev_q <= 1'b0;
    end
    else
    begin
      link_meta_q <= '{sclk: serial_clock_pin_i, ss_n: ss_n_i,
                       mosi: mosi_i};
      link_sync_q <= link_meta_q;
      sclk_prev_q <= link_sync_q.sclk;
    end
  end

  assign sclk_rise = link_sync_q.sclk & ~sclk_prev_q;
  assign sclk_fall = ~link_sync_q.sclk & sclk_prev_q;

  // ****************************************************************
  // Control and sequencing state
  // ****************************************************************
  typedef enum logic [1:0] {ST_STARTUP, ST_READY, ST_BUSY} ars_state_t;

  ars_state_t  state_q;
  logic        port_en_q;
  logic        busy_q;
  logic [31:0] ctrl_q;
  logic [31:0] cmd_q;
  logic [31:0] conv_q [4];
  logic [3:0]  fresh_q;
  logic [31:0] tx_sr_q;
  logic [31:0] rx_sr_q;
  logic [5:0]  bit_cnt_q;
  logic        miso_q;
  logic [31:0] timer_q;
  logic [4:0]  samp_cnt_q;
  logic        frame_done;
  logic        timer_done;
  logic        startup_done;
  logic        link_active;
  logic [1:0]  sel_ch;
  logic [31:0] sel_word;

  assign sel_ch = cmd_q[CMD_SEL_HI:CMD_SEL_LO];

  always_comb
  begin
    sel_word = conv_q[sel_ch];
    sel_word[EOC_BIT] = ~fresh_q[sel_ch];
  end

  // select low, port on; clock alone starts nothing
  assign link_active = port_en_q & ~link_sync_q.ss_n;
  assign frame_done  = link_active & sclk_fall &
                       (bit_cnt_q == 6'(FRAME_BITS - 1));
  assign timer_done  = (state_q == ST_BUSY) &&
                       (timer_q == 32'(BUSY_CYCLES - 1));
  assign startup_done = (state_q == ST_STARTUP) && sample_valid_i &&
                        (samp_cnt_q == 5'(N_SAMPLES - 1));

  // ****************************************************************
  // Result conversion and storage
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < 4; i++)
        conv_q[i] <= DUMMY_WORD;
    end
    else if (sample_valid_i)
    begin
      conv_q[0] <= ars_convert(sample_ch0_i, ctrl_q[CTRL_NEG2]);
      conv_q[1] <= ars_convert(sample_ch1_i, ctrl_q[CTRL_NEG2]);
      conv_q[2] <= ars_convert(sample_ch2_i, ctrl_q[CTRL_NEG2]);
      conv_q[3] <= ars_convert(sample_ch3_i, ctrl_q[CTRL_NEG2]);
    end
  end

  // A new sample in the same cycle as a load keeps the flag set.
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      fresh_q <= 4'h0;
    else if (sample_valid_i)
      fresh_q <= 4'hf;
    else if (timer_done)
      fresh_q[sel_ch] <= 1'b0;
  end

  // ****************************************************************
  // Sequencer: startup, ready, busy
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state_q    <= ST_STARTUP;
      busy_q     <= 1'b1;
      port_en_q  <= 1'b0;
      samp_cnt_q <= 5'h00;
    end
    else
    begin
      case (state_q)
        ST_STARTUP:
        begin
          if (sample_valid_i)
            samp_cnt_q <= samp_cnt_q + 5'h01;
          if (startup_done)
          begin
            state_q   <= ST_READY;
            port_en_q <= 1'b1;
            busy_q    <= 1'b0;
          end
        end
        ST_READY:
        begin
          if (frame_done)
          begin
            busy_q    <= 1'b1;
            port_en_q <= 1'b0;
            state_q   <= ST_BUSY;
          end
        end
        ST_BUSY:
        begin
          if (timer_done)
          begin
            port_en_q <= 1'b1;
            busy_q    <= 1'b0;
            state_q   <= ST_READY;
          end
        end
        default:
          state_q <= ST_STARTUP;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      timer_q <= 32'h00000000;
    else if (state_q != ST_BUSY || timer_done)
      timer_q <= 32'h00000000;
    else
      timer_q <= timer_q + 32'h00000001;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      cmd_q <= 32'h00000000;
    else if (frame_done)
      cmd_q <= {rx_sr_q[30:0], link_sync_q.mosi};
  end

  // ****************************************************************
  // Shift registers
  // ****************************************************************
  // one word each way
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      bit_cnt_q <= 6'h00;
      rx_sr_q   <= 32'h00000000;
    end
    else if (!link_active)
    begin
      // Select released mid-frame drops the partial word.
      bit_cnt_q <= 6'h00;
    end
    else if (sclk_fall)
    begin
      rx_sr_q   <= {rx_sr_q[30:0], link_sync_q.mosi};
      bit_cnt_q <= frame_done ? 6'h00 : bit_cnt_q + 6'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      tx_sr_q <= DUMMY_WORD;
      miso_q  <= 1'b0;
    end
    else if (startup_done)
      tx_sr_q <= DUMMY_WORD;
    else if (timer_done)
      tx_sr_q <= sel_word;
    else if (link_active && sclk_rise)
    begin
      miso_q  <= tx_sr_q[31];
      tx_sr_q <= {tx_sr_q[30:0], 1'b0};
    end
  end

  assign miso_o    = miso_q;
  assign miso_oe_o = link_active;
  assign busy_o    = busy_q;

  // ****************************************************************
  // AHB-Lite register port
  // ****************************************************************
  logic        ahb_go;
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] rdata_q;
  ars_status_t status;

  assign ahb_go = hsel_i & hready_i & htrans_i[1];

  always_comb
  begin
    status         = '0;
    status.busy    = busy_q;
    status.port_en = port_en_q;
    status.ready   = (state_q != ST_STARTUP);
    status.fresh   = fresh_q[sel_ch];
    status.channel = sel_ch;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= ahb_go & hwrite_i & (haddr_i[31:8] == 24'h0);
      wr_addr_q <= haddr_i[7:0];
    end
  end

  // Only the negative shift choice is writable; it steers conversion.
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      ctrl_q <= CTRL_RESET;
    else if (wr_pend_q && wr_addr_q == ADDR_CTRL)
      ctrl_q <= {31'h0, hwdata_i[CTRL_NEG2]};
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      rdata_q <= 32'h00000000;
    else if (ahb_go && !hwrite_i)
    begin
      if (haddr_i[7:0] == ADDR_RESULT && haddr_i[31:8] == 24'h0)
        rdata_q <= sel_word;
      else if (haddr_i[7:0] == ADDR_CTRL && haddr_i[31:8] == 24'h0)
        rdata_q <= ctrl_q;
      else if (haddr_i[7:0] == ADDR_STATUS && haddr_i[31:8] == 24'h0)
        rdata_q <= status;
      else if (haddr_i[7:0] == ADDR_CMD && haddr_i[31:8] == 24'h0)
        rdata_q <= cmd_q;
      else
        rdata_q <= 32'h00000000;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_q;

endmodule
`default_nettype wire

// ### sim/ars_spi_master.sv
// Behavioural serial master for the ADC result slave.
`timescale 1ns/1ps
`default_nettype none
module ars_spi_master
(
  // Link pins
  input  wire logic busy_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      ss_n_o,
  output logic      mosi_o
);
  // The clock idles low between frames, as the slave expects.
  initial
  begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  task automatic xfer(input logic [31:0] cmd, input logic split,
                      input logic hold, output logic [31:0] rx);
    wait (busy_i === 1'b0);
    #13 ss_n_o = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      #40 sclk_o = 1'b1;
      mosi_o = cmd[i];
      #40 sclk_o = 1'b0;
      rx[i] = miso_i;
      if (split && i == 16)
        #400;
    end
    #40 ss_n_o = hold;
    mosi_o = ~mosi_o;
    wait (busy_i === 1'b1);
    wait (busy_i === 1'b0);
  endtask
endmodule
`default_nettype wire

// ### sim/ars_spi_slave_asserts.sv
// Port checks for the ADC result serial slave.
`timescale 1ns/1ps
`default_nettype none
module ars_chk
  import ars_pkg::*;
#(
  parameter int unsigned BUSY_CYCLES = BUSY_CYCLES_DEF
)
(
  // Observed ports
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sample_valid_i,
  input wire logic serial_clock_pin_i,
  input wire logic ss_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic [15:0] cnt_q;
  logic        seen_q;
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i || !busy_o)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 16'h1;
  end
  // Startup busy is not timed, so only frame-driven busy is measured.
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      seen_q <= 1'b0;
    else if ($rose(busy_o))
      seen_q <= 1'b1;
  end
  rst_state_a:
    assert property ($rose(nrst_i) |-> busy_o && !miso_oe_o && !miso_o)
    else $error("outputs wrong after reset");
  boot_hold_a:
    assert property (busy_o && !seen_q && !sample_valid_i |=> busy_o)
    else $error("busy dropped without a sample");
  oe_busy_a:
    assert property (miso_oe_o |-> !busy_o)
    else $error("port enabled while busy");
  busy_min_a:
    assert property ($rose(busy_o) |=> busy_o [*8])
    else $error("busy pulse too short");
  busy_len_a:
    assert property ($fell(busy_o) && seen_q |->
      cnt_q >= BUSY_CYCLES - 2 && cnt_q <= BUSY_CYCLES + 2)
    else $error("busy length off");
  busy_rise_a:
    assert property ($rose(busy_o) |-> !$past(serial_clock_pin_i))
    else $error("busy rose inside a clock pulse");
  miso_edge_a:
    assert property (miso_oe_o && $past(miso_oe_o, 4) && $changed(miso_o)
      |-> $past(serial_clock_pin_i, 2) || $past(serial_clock_pin_i, 3) ||
      $past(serial_clock_pin_i, 4) || $past(serial_clock_pin_i, 5))
    else $error("data changed away from a rising clock");
  ss_oe_a:
    assert property (ss_n_i [*4] |-> !miso_oe_o)
    else $error("data driven while deselected");
  cover property ($rose(busy_o));
  cover property ($fell(busy_o) && seen_q);
  cover property ($rose(miso_oe_o));
endmodule
bind ars_spi_slave ars_chk #(
  .BUSY_CYCLES(BUSY_CYCLES)
) chk_u (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .sample_valid_i(sample_valid_i),
  .serial_clock_pin_i(serial_clock_pin_i),
  .ss_n_i(ss_n_i),
  .miso_o(miso_o),
  .miso_oe_o(miso_oe_o),
  .busy_o(busy_o)
);
`default_nettype wire

// ### sim/tb_adc_result_spi_slave.sv
// Self-checking bench for the ADC result serial slave.
`timescale 1ns/1ps
`default_nettype none
module tb_adc_result_spi_slave
  import ars_pkg::*;
;
  typedef struct {
    logic [31:0] din;
    logic [1:0]  ch;
    logic        neg2;
    logic        split;
    logic [31:0] dout;
  } ars_row_t;
  localparam logic [31:0] LMASK = 32'hffffffe0;
  ars_row_t rows [8] = '{
    '{32'h7fffff00, 2'h0, 1'b0, 1'b0, 32'h30000000},
    '{32'h80000000, 2'h1, 1'b1, 1'b1, 32'h0fffffff},
    '{32'h00000000, 2'h2, 1'b0, 1'b0, 32'h20000000},
    '{32'h40000000, 2'h3, 1'b0, 1'b1, 32'h28000000},
    '{32'hc0000000, 2'h0, 1'b0, 1'b0, 32'h17ffffff},
    '{32'hc0000000, 2'h1, 1'b1, 1'b0, 32'h1fffffff},
    '{32'h7ffffe00, 2'h2, 1'b0, 1'b1, 32'h2fffffc0},
    '{32'h80000200, 2'h3, 1'b1, 1'b0, 32'h1000007f}
  };
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        sv = 1'b0;
  logic [31:0] ch [4] = '{default: 32'h0};
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] rx;
  logic [31:0] rd;
  logic [31:0] cmd;
  logic [31:0] exp;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wire logic        sclk, ss_n, mosi, dmiso, miso, oe, busy, hrdy, hresp;
  wire logic [31:0] hrdata;
  always #5 clk_i = ~clk_i;
  // An undriven data line shows a toggling pattern, not a held value.
  assign miso = oe ? dmiso : ~sclk;
  ars_spi_slave #(.BUSY_CYCLES(50), .N_SAMPLES(2)) dut_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .sample_valid_i(sv),
    .sample_ch0_i(ch[0]), .sample_ch1_i(ch[1]),
    .sample_ch2_i(ch[2]), .sample_ch3_i(ch[3]),
    .serial_clock_pin_i(sclk), .ss_n_i(ss_n), .mosi_i(mosi),
    .miso_o(dmiso), .miso_oe_o(oe), .busy_o(busy),
    .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata)
  );
  ars_spi_master m_u (
    .busy_i(busy), .miso_i(miso), .sclk_o(sclk),
    .ss_n_o(ss_n), .mosi_o(mosi)
  );
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_i);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic push(input logic [31:0] v, input logic [1:0] c);
    @(posedge clk_i);
    sv <= 1'b1;
    for (int k = 0; k < 4; k++)
      ch[k] <= (k == c) ? v : ~v;
    @(posedge clk_i);
    sv <= 1'b0;
  endtask
  task automatic boot();
    nrst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    chk("busy", 32'h1, {31'h0, busy});
    push(32'h0, 2'h0);
    push(32'h0, 2'h0);
  endtask
  initial
  begin
    boot();
    foreach (rows[i])
    begin
      bus(ADDR_CTRL, 1'b1, {31'h0, rows[i].neg2}, rd);
      push(rows[i].din, rows[i].ch);
      cmd = {6'h28, rows[i].ch, 24'h0};
      m_u.xfer(cmd, rows[i].split, rows[i].split, rx);
      exp = (rows[(i + 7) % 8].dout | 32'h80000000) & LMASK;
      if (i == 0)
        chk("first word", DUMMY_WORD, rx);
      else
        chk("stale word", exp, rx & LMASK);
      bus(ADDR_CMD, 1'b0, 32'h0, rd);
      chk("command", cmd, rd);
      bus(ADDR_RESULT, 1'b0, 32'h0, rd);
      chk("result", rows[i].dout | 32'h80000000, rd);
      m_u.xfer(cmd, 1'b0, 1'b0, rx);
      chk("word", rows[i].dout & LMASK, rx & LMASK);
      $display("test row %0d done", i);
    end
    boot();
    bus(ADDR_CTRL, 1'b0, 32'h0, rd);
    chk("ctrl", CTRL_RESET, rd);
    bus(ADDR_STATUS, 1'b0, 32'h0, rd);
    chk("status", 32'h0000000e, rd);
    bus(ADDR_RESULT, 1'b0, 32'h0, rd);
    chk("fresh result", 32'h20000000, rd);
    chk("bus response", 32'h2, {30'h0, hrdy, hresp});
    bus(8'h30, 1'b1, 32'hffffffff, rd);
    bus(8'h30, 1'b0, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    m_u.xfer(32'ha0000000, 1'b1, 1'b0, rx);
    chk("dummy", DUMMY_WORD, rx);
    $display("test reset done");
    summarize();
  end
endmodule
`default_nettype wire
